// file: design/urff_pkg.sv
// Shared constants, register map and types of the UART receive FIFO block.
package urff_pkg;

  // Character format and FIFO geometry.
  localparam int DATA_W        = 8;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_HALF     = 8;
  localparam int TICKS_PER_BIT = 16;

  // Oversample and bit counter landmarks: middle of the start bit, end of a bit, last data bit.
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // APB register byte addresses.
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_ACK    = 8'h0C;
  localparam logic [7:0] ADDR_INTSTS = 8'h10;
  localparam logic [7:0] ADDR_INTMSK = 8'h14;

  // Field positions.
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int ACK_BIT        = 0;
  localparam int EVENT_W        = 5;
  localparam int FLAG_W         = 3;

  // Reset values.
  localparam logic             CTRL_RESET   = 1'b0;
  localparam logic [EVENT_W-1:0] INTMSK_RESET = 5'h00;

  // FIFO status flags, also the low bits of the status register.
  typedef struct packed {
    logic full;
    logic half;
    logic nonempty;
  } urff_flags_t;

  // Interrupt events, also the layout of status and mask registers.
  typedef struct packed {
    logic frameErr;
    logic overflow;
    logic fullRise;
    logic halfRise;
    logic charRecv;
  } urff_events_t;

  // Receiver states.
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } urff_rx_state_t;

endpackage

// file: design/urff_char_mem.sv
// Small character store of the receive FIFO with registered read data.
`timescale 1ns/1ps
module urff_char_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // A write to the slot being read is passed straight through, so the
  // first character into an empty FIFO is presented without a lag.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
  end

endmodule

// file: design/urff_receiver.sv
// UART receiver with a sixteen-character FIFO, flags and APB registers.
`timescale 1ns/1ps
// What this block does
// - The FIFO holds at most sixteen received characters.
// - Full flag rises as soon as the sixteenth unread character arrives.
// - Clear high at a rising edge resets the FIFO on that edge.
// - Clear discards all characters and drops every FIFO flag.
// - Character in flight is stored if valid, clear low at stop and a slot free.
// - Half flag is high exactly while eight or more characters wait.
// - Frame is eight data bits, one stop bit, no parity.
// - Nonempty is high while a character waits; oldest is presented.
module urff_receiver (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      oversampleTick,
  input  wire logic                      rxLine,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [urff_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  output urff_pkg::urff_flags_t          fifoFlags
);

  localparam int PTR_W = $clog2(urff_pkg::FIFO_DEPTH);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(urff_pkg::FIFO_DEPTH);
  localparam logic [PTR_W:0] CNT_HALF = (PTR_W+1)'(urff_pkg::FIFO_HALF);

  //////////////////////////////////////////////////////////////////////////
  // Line synchroniser and receive state machine.

  logic                         lineSync1;
  logic                         lineSync2;
  logic                         lineSync3;
  logic                         lineLevel;
  urff_pkg::urff_rx_state_t     state;
  urff_pkg::urff_rx_state_t     next_state;
  logic [3:0]                   tickCnt;
  logic [3:0]                   next_tickCnt;
  logic [2:0]                   bitCnt;
  logic [2:0]                   next_bitCnt;
  logic [urff_pkg::DATA_W-1:0]  shiftReg;
  logic [urff_pkg::DATA_W-1:0]  next_shiftReg;
  logic                         stopEnd;
  logic                         storeChar;
  logic                         frameErr;

  // Three stages; the settled level only moves when stages two and three
  // agree, which also filters single-sample glitches on the line.
  always_ff @(posedge clk) begin
    if (srst) begin
      lineSync1 <= 1'b1;
      lineSync2 <= 1'b1;
      lineSync3 <= 1'b1;
      lineLevel <= 1'b1;
    end else begin
      lineSync1 <= rxLine;
      lineSync2 <= lineSync1;
      lineSync3 <= lineSync2;
      if (lineSync2 == lineSync3) begin
        lineLevel <= lineSync3;
      end
    end
  end

  // End of the stop bit decides between a good character and a bad frame.
  assign stopEnd   = (state == urff_pkg::RX_STOP) && oversampleTick &&
                     (tickCnt == urff_pkg::TICK_LAST);
  assign storeChar = stopEnd && lineLevel;
  assign frameErr  = stopEnd && !lineLevel;

  // Everything advances only on oversample ticks, sixteen to a bit.
  always_comb begin
    next_state    = state;
    next_tickCnt  = tickCnt;
    next_bitCnt   = bitCnt;
    next_shiftReg = shiftReg;
    if (oversampleTick) begin
      next_tickCnt = tickCnt + 4'h1;
      case (state)
        urff_pkg::RX_IDLE: begin
          next_tickCnt = '0;
          if (!lineLevel) begin
            next_state = urff_pkg::RX_START;
          end
        end
        urff_pkg::RX_START: begin
          // Realign to mid start bit so later samples land mid bit.
          if (tickCnt == urff_pkg::TICK_MID) begin
            next_tickCnt = '0;
            next_bitCnt  = '0;
            next_state   = lineLevel ? urff_pkg::RX_IDLE : urff_pkg::RX_DATA;
          end
        end
        urff_pkg::RX_DATA: begin
          if (tickCnt == urff_pkg::TICK_LAST) begin
            next_shiftReg = {lineLevel, shiftReg[urff_pkg::DATA_W-1:1]};
            next_bitCnt   = bitCnt + 3'h1;
            if (bitCnt == urff_pkg::BIT_LAST) begin
              next_state = urff_pkg::RX_STOP;
            end
          end
        end
        urff_pkg::RX_STOP: begin
          if (tickCnt == urff_pkg::TICK_LAST) begin
            next_state = urff_pkg::RX_IDLE;
          end
        end
        default: begin
          next_state = urff_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // The receiver is deliberately left running through a FIFO clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      state    <= urff_pkg::RX_IDLE;
      tickCnt  <= '0;
      bitCnt   <= '0;
      shiftReg <= '0;
    end else begin
      state    <= next_state;
      tickCnt  <= next_tickCnt;
      bitCnt   <= next_bitCnt;
      shiftReg <= next_shiftReg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive FIFO and its flags.

  logic                         fifoClear;
  logic                         readAck;
  logic [PTR_W-1:0]             wrPtr;
  logic [PTR_W-1:0]             rdPtr;
  logic [PTR_W-1:0]             next_rdPtr;
  logic [PTR_W:0]               count;
  logic [PTR_W:0]               next_count;
  logic                         doPop;
  logic                         hasRoom;
  logic                         doPush;
  logic                         overflow;
  logic [urff_pkg::DATA_W-1:0]  rxChar;
  urff_pkg::urff_flags_t        next_flags;

  // A pop frees a slot in the same cycle, so a full FIFO still takes a
  // character that lands on the acknowledge edge.
  assign doPop    = readAck && (count != '0) && !fifoClear;
  assign hasRoom  = (count != CNT_FULL) || doPop;
  assign doPush   = storeChar && !fifoClear && hasRoom;
  assign overflow = storeChar && !fifoClear && !hasRoom;
  assign next_rdPtr = fifoClear ? '0 : rdPtr + PTR_W'(doPop);
  assign next_count = fifoClear ? '0 :
                      count + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
  assign next_flags.nonempty = (next_count != '0);
  assign next_flags.half     = (next_count >= CNT_HALF);
  assign next_flags.full     = (next_count == CNT_FULL);

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      count     <= '0;
      fifoFlags <= '0;
    end else begin
      wrPtr     <= fifoClear ? '0 : wrPtr + PTR_W'(doPush);
      rdPtr     <= next_rdPtr;
      count     <= next_count;
      fifoFlags <= next_flags;
    end
  end

  // Read data always shows the slot the next read pointer names.
  urff_char_mem #(
    .DATA_W (urff_pkg::DATA_W),
    .ADDR_W (PTR_W)
  ) charMem (
    .clk    (clk),
    .wrEn   (doPush),
    .wrAddr (wrPtr),
    .wrData (shiftReg),
    .rdAddr (next_rdPtr),
    .rdData (rxChar)
  );

  //////////////////////////////////////////////////////////////////////////
  // APB slave, control, interrupt status and mask.

  logic                         busWrite;
  logic                         busRead;
  logic                         addrKnown;
  logic [31:0]                  readMux;
  logic [urff_pkg::EVENT_W-1:0] intStatus;
  logic [urff_pkg::EVENT_W-1:0] next_intStatus;
  logic [urff_pkg::EVENT_W-1:0] intMask;
  logic [urff_pkg::EVENT_W-1:0] next_intMask;
  logic [urff_pkg::EVENT_W-1:0] w1cBits;
  urff_pkg::urff_events_t       events;

  // pready is registered, so every access takes exactly one wait state.
  assign busWrite  = psel && penable && pready && pwrite;
  assign busRead   = psel && penable && !pready && !pwrite;
  assign addrKnown = (paddr == urff_pkg::ADDR_CTRL)   ||
                     (paddr == urff_pkg::ADDR_STATUS) ||
                     (paddr == urff_pkg::ADDR_RXDATA) ||
                     (paddr == urff_pkg::ADDR_ACK)    ||
                     (paddr == urff_pkg::ADDR_INTSTS) ||
                     (paddr == urff_pkg::ADDR_INTMSK);
  assign readAck   = busWrite && (paddr == urff_pkg::ADDR_ACK) &&
                     pwdata[urff_pkg::ACK_BIT];
  assign readMux   =
    (paddr == urff_pkg::ADDR_CTRL)   ? 32'(fifoClear) :
    (paddr == urff_pkg::ADDR_STATUS) ? 32'(fifoFlags) :
    (paddr == urff_pkg::ADDR_RXDATA) ? 32'(rxChar) :
    (paddr == urff_pkg::ADDR_INTSTS) ? 32'(intStatus) :
    (paddr == urff_pkg::ADDR_INTMSK) ? 32'(intMask) : 32'h0000_0000;

  // Events; a new event wins over a write-one-to-clear of the same bit.
  assign events.charRecv = doPush;
  assign events.halfRise = next_flags.half && !fifoFlags.half;
  assign events.fullRise = next_flags.full && !fifoFlags.full;
  assign events.overflow = overflow;
  assign events.frameErr = frameErr;
  assign w1cBits = (busWrite && paddr == urff_pkg::ADDR_INTSTS) ?
                   pwdata[urff_pkg::EVENT_W-1:0] : '0;
  assign next_intStatus = (intStatus & ~w1cBits) | events;

  // The interrupt is built from the mask written on the same edge, so a
  // mask change never leaves one stale cycle on the interrupt line.
  assign next_intMask = (busWrite && paddr == urff_pkg::ADDR_INTMSK) ?
                        pwdata[urff_pkg::EVENT_W-1:0] : intMask;

  always_ff @(posedge clk) begin
    if (srst) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= '0;
      fifoClear <= urff_pkg::CTRL_RESET;
      intStatus <= '0;
      intMask   <= urff_pkg::INTMSK_RESET;
      irq       <= 1'b0;
    end else begin
      pready    <= psel && penable && !pready;
      pslverr   <= psel && penable && !pready && !addrKnown;
      prdata    <= busRead ? readMux : 32'h0000_0000;
      if (busWrite && paddr == urff_pkg::ADDR_CTRL) begin
        fifoClear <= pwdata[urff_pkg::CTRL_CLEAR_BIT];
      end
      intMask   <= next_intMask;
      intStatus <= next_intStatus;
      irq       <= |(next_intStatus & next_intMask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.

  count_bound_a: assert property (
    @(posedge clk) disable iff (srst) count <= CNT_FULL)
    else $error("FIFO count above depth");

  push_grows_a: assert property (
    @(posedge clk) disable iff (srst)
    (doPush && !doPop) |=> (count == $past(count) + 1'b1))
    else $error("stored character did not raise count");

  full_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    fifoFlags.full == (count == CNT_FULL))
    else $error("full flag disagrees with count");

  clear_empties_a: assert property (
    @(posedge clk) disable iff (srst)
    fifoClear |=> (count == '0) && (fifoFlags == '0) && (wrPtr == rdPtr))
    else $error("clear did not empty FIFO on its edge");

  clear_blocks_a: assert property (
    @(posedge clk) disable iff (srst)
    (storeChar && fifoClear) |=> (count == '0))
    else $error("character stored while clear high");

  half_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    fifoFlags.half == (count >= CNT_HALF))
    else $error("half flag disagrees with count");

  nonempty_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    fifoFlags.nonempty == (count != '0))
    else $error("nonempty flag disagrees with count");

  tick_gated_a: assert property (
    @(posedge clk) disable iff (srst)
    (state != $past(state)) |-> $past(oversampleTick))
    else $error("receiver moved without a tick");

  stop_high_a: assert property (
    @(posedge clk) disable iff (srst)
    doPush |-> (state == urff_pkg::RX_STOP) && lineLevel &&
               (bitCnt == '0))
    else $error("character stored without a valid stop bit");

  irq_level_a: assert property (
    @(posedge clk) disable iff (srst)
    (|(intStatus & intMask)) |-> irq)
    else $error("unmasked status set but interrupt low");

endmodule

// file: testbench/urff_tx_model.sv
// Behavioural model of the remote UART transmitter on the serial line.
`timescale 1ns/1ps
module urff_tx_model (
  input  wire logic clk,
  input  wire logic tick,
  output logic      line
);
  // The line idles high between frames.
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // One frame: start, eight data bits LSB first, then stop.
  // Bits move only on enable pulses, so no second clock is made.
  // A low stop bit is sent only when a scenario asks for a framing fault.
  task automatic sendChar(input logic [7:0] ch, input logic stopOk);
    logic [9:0] frame;
    frame = {stopOk, ch, 1'b0};
    for (int b = 0; b < 10; b++) begin
      line <= frame[b];
      repeat (16) @(posedge clk iff tick);
    end
    line <= 1'b1;
    repeat (8) @(posedge clk iff tick);
  endtask
endmodule

// file: testbench/tb_urff_receiver.sv
// Self-checking bench of the UART receive FIFO and its flags.
`timescale 1ns/1ps
module tb_urff_receiver;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        tick = 1'b0;
  logic        rxLine;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        lastErr;
  logic [31:0] rd;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          tickDiv = 2;
  int          divCnt = 0;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD   = 115_200;
  urff_pkg::urff_flags_t fifoFlags;

  urff_receiver uut (
    .clk(clk), .srst(srst), .oversampleTick(tick), .rxLine(rxLine),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .fifoFlags(fifoFlags)
  );

  urff_tx_model remote (.clk(clk), .tick(tick), .line(rxLine));

  // A 40 MHz clock and a one-cycle oversample enable every tickDiv cycles.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    divCnt <= (divCnt >= tickDiv - 1) ? 0 : divCnt + 1;
    tick   <= (divCnt >= tickDiv - 1);
  end

  // Cycle ceiling cuts a hang short; the full run needs about 14000.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and report.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; waits on pready, never on a fixed count.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset state, and an unmapped address refused with an error.
  task automatic testReset();
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
    rdChk("intMask", urff_pkg::ADDR_INTMSK, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("slverr", 1, lastErr);
  endtask

  // One good character, then one with a low stop bit.
  task automatic testSingle();
    remote.sendChar(8'hA5, 1'b1);
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0001);
    rdChk("rxData", urff_pkg::ADDR_RXDATA, 32'h0000_00A5);
    rdChk("intSts", urff_pkg::ADDR_INTSTS, 32'h0000_0001);
    apb(1'b1, urff_pkg::ADDR_INTSTS, 32'h0000_001F);
    apb(1'b1, urff_pkg::ADDR_ACK, 32'h0000_0001);
    remote.sendChar(8'h3C, 1'b0);
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
    rdChk("intSts", urff_pkg::ADDR_INTSTS, 32'h0000_0010);
    apb(1'b1, urff_pkg::ADDR_INTSTS, 32'h0000_001F);
  endtask

  // Seventeen characters: half at eight, full at sixteen, overflow.
  task automatic testFill();
    int c;
    for (int i = 0; i < 17; i++) begin
      remote.sendChar(8'h40 + 8'(i), 1'b1);
      c = (i < 15) ? i + 1 : 16;
      rdChk("status", urff_pkg::ADDR_STATUS,
            {29'h0, c == 16, c >= 8, 1'b1});
    end
    chk("flagsPort", 32'h0000_0007, 32'(fifoFlags));
    rdChk("intSts", urff_pkg::ADDR_INTSTS, 32'h0000_000F);
    apb(1'b1, urff_pkg::ADDR_INTMSK, 32'h0000_0008);
    chk("irqOn", 1, irq);
    apb(1'b1, urff_pkg::ADDR_INTSTS, 32'h0000_001F);
    chk("irqOff", 0, irq);
    apb(1'b1, urff_pkg::ADDR_INTMSK, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      rdChk("rxData", urff_pkg::ADDR_RXDATA, 32'h40 + i);
      apb(1'b1, urff_pkg::ADDR_ACK, 32'h0000_0001);
    end
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
  endtask

  // The remote is paused once half rises; the eight then drain in a burst.
  task automatic testFlow();
    int n;
    n = 0;
    while (fifoFlags.half !== 1'b1 && n < 20) begin
      remote.sendChar(8'h60 + 8'(n), 1'b1);
      n++;
    end
    chk("flowCount", urff_pkg::FIFO_HALF, n);
    for (int i = 0; i < urff_pkg::FIFO_HALF; i++) begin
      rdChk("rxData", urff_pkg::ADDR_RXDATA, 32'h60 + i);
      apb(1'b1, urff_pkg::ADDR_ACK, 32'h0000_0001);
    end
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
  endtask

  // One character at the reference rate, the divider worked out from the
  // clock frequency as a controlling processor would do it.
  task automatic testBaud();
    tickDiv <= CLK_HZ / (urff_pkg::TICKS_PER_BIT * BAUD);
    remote.sendChar(8'hC3, 1'b1);
    rdChk("rxData", urff_pkg::ADDR_RXDATA, 32'h0000_00C3);
    apb(1'b1, urff_pkg::ADDR_ACK, 32'h0000_0001);
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
    tickDiv <= 2;
  endtask

  // Clear drops stored data; a frame finishing after release is kept.
  task automatic testClear();
    remote.sendChar(8'h21, 1'b1);
    remote.sendChar(8'h22, 1'b1);
    apb(1'b1, urff_pkg::ADDR_CTRL, 32'h0000_0001);
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
    remote.sendChar(8'h11, 1'b1);
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0000);
    fork
      remote.sendChar(8'h5A, 1'b1);
      begin
        repeat (100) @(posedge clk);
        apb(1'b1, urff_pkg::ADDR_CTRL, 32'h0000_0000);
      end
    join
    rdChk("status", urff_pkg::ADDR_STATUS, 32'h0000_0001);
    rdChk("rxData", urff_pkg::ADDR_RXDATA, 32'h0000_005A);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset for three cycles, let the line settle, then run scenarios.
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    testReset();
    testSingle();
    testFill();
    testFlow();
    testBaud();
    testClear();
    wrap_up();
  end
endmodule
